// File: design/sicf_pkg.sv
/*
 * Shared constants, types and decode helpers for the serial interface
 * configuration bank. Assumes a single-lane register-access frame of
 * command byte, three address bytes and one data byte.
 */
package sicf_pkg;
	// register-access addresses
	localparam logic [23:0] CFG1_NV_ADDR = 24'h000002;
	localparam logic [23:0] CFG1_VOL_ADDR = 24'h070002;
	localparam logic [23:0] CFG2_NV_ADDR = 24'h000003;
	localparam logic [23:0] CFG2_VOL_ADDR = 24'h070003;
	// factory defaults and writable-bit masks
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] CFG1_WMASK = 8'hF2;
	localparam logic [7:0] CFG2_WMASK = 8'h70;
	// field positions
	localparam int CFG1_QUAD_BIT = 1;
	localparam int LAT_MSB = 7;
	localparam int LAT_LSB = 4;
	localparam int CFG2_FOUR_BIT = 6;
	localparam int CFG2_LANE3_RESET_ALT_ENABLE_BIT = 5;
	localparam int CFG2_TWO_BIT = 4;
	// opcodes (values arbitrary)
	localparam logic [7:0] WRITE_ANY_REGISTER_CMD = 8'hA1;
	localparam logic [7:0] READ_ANY_REGISTER_CMD = 8'hA2;
	localparam logic [7:0] READ_CFG_TWO_CMD = 8'hA3;
	// frame bit positions
	localparam logic [5:0] BITS_CMD = 6'h08;
	localparam logic [5:0] BITS_ADDR_END = 6'h20;
	localparam logic [5:0] BITS_WRITE_END = 6'h28;
	// synchroniser bit positions and reset pattern {cs,wr,wp,l3}
	localparam int S_CS = 3;
	localparam int S_WR = 2;
	localparam int S_WP = 1;
	localparam int S_L3 = 0;
	localparam logic [3:0] SYNC_RESET = 4'hB;

	typedef enum logic [1:0] {SICF_SINGLE, SICF_DUAL, SICF_QUAD} sicf_proto_t;
	typedef enum logic [2:0] {
		SEL_NONE, SEL_C1NV, SEL_C1V, SEL_C2NV, SEL_C2V
	} sicf_sel_t;

	// address to register copy
	function automatic sicf_sel_t reg_select(input logic [23:0] addr);
		case (addr)
			CFG1_NV_ADDR: reg_select = SEL_C1NV;
			CFG1_VOL_ADDR: reg_select = SEL_C1V;
			CFG2_NV_ADDR: reg_select = SEL_C2NV;
			CFG2_VOL_ADDR: reg_select = SEL_C2V;
			default: reg_select = SEL_NONE;
		endcase
	endfunction
endpackage

// File: design/sicf_link_if.sv
/*
 * Carrier between the serial-clock front end and the system-clock bank.
 * Assumes write fields are only sampled by the bank after chip select
 * has risen, and the volatile words change only between frames.
 */
`timescale 1ns/100ps
interface sicf_link_if;
	logic wr_done;
	logic [23:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] cfg1_vol;
	logic [7:0] cfg2_vol;
	modport link (output wr_done, wr_addr, wr_data, input cfg1_vol, cfg2_vol);
	modport core (input wr_done, wr_addr, wr_data, output cfg1_vol, cfg2_vol);
endinterface

// File: design/sicf_link.sv
/*
 * Serial-clock front end: shifts in single-lane register-access frames
 * and shifts out register reads. Assumes mode 0 timing and that the
 * serial clock stands still while chip select is high.
 */
`timescale 1ns/100ps
module sicf_link (
	input wire logic sck,
	input wire logic cs_n,
	input wire logic io0_in,
	output logic io1_out,
	output logic io1_oe,
	sicf_link_if.link lk
);
	import sicf_pkg::*;

	logic [5:0] cnt_q, cnt_d;
	logic [39:0] sh_q, sh_d, sh_nx;
	logic done_q, done_d;
	logic [15:0] snap_m_q, snap_q;
	logic [7:0] tx_q, tx_d;
	logic tx_en_q, tx_en_d;
	logic out_q, oe_q;

	// frame decode; counter saturates so extra bits cannot spoil fields
	always_comb begin
		sh_nx = {sh_q[38:0], io0_in};
		sh_d = (cnt_q == BITS_WRITE_END) ? sh_q : sh_nx;
		cnt_d = (cnt_q == BITS_WRITE_END) ? cnt_q : cnt_q + 6'h01;
		done_d = (cnt_q == 6'h00) ? 1'b0 : done_q;
		if (cnt_q == BITS_WRITE_END - 6'h01 &&
			sh_nx[39:32] == WRITE_ANY_REGISTER_CMD)
			done_d = 1'b1;
		tx_en_d = tx_en_q;
		tx_d = {tx_q[6:0], tx_q[7]}; // byte repeats while clocked
		if (cnt_q == BITS_CMD - 6'h01 && sh_nx[7:0] == READ_CFG_TWO_CMD) begin
			tx_d = snap_q[15:8];
			tx_en_d = 1'b1;
		end else if (cnt_q == BITS_ADDR_END - 6'h01 &&
			sh_nx[31:24] == READ_ANY_REGISTER_CMD) begin
			tx_en_d = 1'b1;
			case (reg_select(sh_nx[23:0]))
				SEL_C1NV, SEL_C1V: tx_d = snap_q[7:0];
				SEL_C2NV, SEL_C2V: tx_d = snap_q[15:8];
				default: tx_d = CFG_RESET;
			endcase
		end
	end

	// frame state ends with the frame's own chip select
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			cnt_q <= 6'h00;
			tx_q <= CFG_RESET;
			tx_en_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tx_q <= tx_d;
			tx_en_q <= tx_en_d;
		end
	end

	// data fields must survive chip select rising for the bank to read
	always_ff @(posedge sck) begin
		sh_q <= sh_d;
		done_q <= done_d;
		snap_m_q <= {lk.cfg2_vol, lk.cfg1_vol};
		snap_q <= snap_m_q;
	end

	// output launched on the falling edge for mode 0 sampling
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			out_q <= tx_q[7];
			oe_q <= tx_en_q;
		end
	end

	assign io1_out = out_q;
	assign io1_oe = oe_q;
	assign lk.wr_done = done_q;
	assign lk.wr_addr = sh_q[31:8];
	assign lk.wr_data = sh_q[7:0];
endmodule

// File: design/sicf_cfg_top.sv
/*
 * Interface configuration bank: volatile and non-volatile copies of the
 * two configuration registers, protocol select and lane-pin functions.
 * Assumes pins and the serial clock are asynchronous to sys_clk and that
 * the serial clock stands still between frames.
 */
// Behaviour
// - quad data bit widens path except in dual protocol; write-protect and lane-3 pins carry data
// - with alt reset and four-lane width, lane 3 is data in frame, reset outside frame
// - four-lane width forces internal write-protect to one
// - second config written by write-any; read by dedicated or read-any
// - second config register defaults to all zero
// - second config bit 6 selects quad protocol
// - second config bit 4 selects dual protocol
// - reserved bits of second config stay zero in both copies
// - reads return volatile copy; only volatile copy steers behaviour
// - non-volatile write updates both; hardware reset reloads volatile
// - latency counts full serial clocks, mode cycles included
// - both protocol bits set falls back to single protocol
`timescale 1ns/100ps
module sicf_cfg_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic io0_in,
	input wire logic wp_n_in,
	input wire logic lane3_in,
	output logic io1_out,
	output logic io1_oe,
	output sicf_pkg::sicf_proto_t protocol_mode,
	output logic four_lane_data,
	output logic lane2_is_data,
	output logic lane3_is_data,
	output logic lane3_is_reset,
	output logic write_protect_int,
	output logic hw_reset_active,
	output logic [3:0] read_latency_code
);
	import sicf_pkg::*;

	sicf_link_if lk ();

	sicf_link u_link (
		.sck(sck),
		.cs_n(cs_n),
		.io0_in(io0_in),
		.io1_out(io1_out),
		.io1_oe(io1_oe),
		.lk(lk)
	);

	logic [3:0] meta_q, meta_d;
	logic [3:0] sync_q, sync_d;
	logic cs_last_q, cs_last_d;
	logic cs_rise, commit;
	sicf_sel_t wsel;
	logic [7:0] c1_nv_q, c1_nv_d, c1_v_q, c1_v_d;
	logic [7:0] c2_nv_q, c2_nv_d, c2_v_q, c2_v_d;
	logic [7:0] eff1_q, eff1_d, eff2_q, eff2_d;
	logic four_lane_protocol_enable, two_lane_protocol_enable, lane3_reset_alt_enable, quadd, cs_lo;
	sicf_proto_t proto_q, proto_d;
	logic four_q, four_d;
	logic l3_data_q, l3_data_d;
	logic l3_rst_q, l3_rst_d;
	logic wp_q, wp_d;
	logic hw_q, hw_d;
	logic [3:0] lat_q, lat_d;

	// two-flop synchronisers for chip select, write flag and pins
	always_comb begin
		meta_d = {cs_n, lk.wr_done, wp_n_in, lane3_in};
		sync_d = meta_q;
		cs_last_d = sync_q[S_CS];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meta_q <= SYNC_RESET;
			sync_q <= SYNC_RESET;
			cs_last_q <= 1'b1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			cs_last_q <= cs_last_d;
		end
	end

	// write fields are frozen once chip select is high, so sampling the
	// wide address and data after the synced rise is safe
	assign cs_rise = sync_q[S_CS] & ~cs_last_q;
	assign commit = cs_rise & sync_q[S_WR];
	assign wsel = reg_select(lk.wr_addr);

	// register copies; hardware reset outranks a coinciding write
	always_comb begin
		c1_nv_d = c1_nv_q;
		c1_v_d = c1_v_q;
		c2_nv_d = c2_nv_q;
		c2_v_d = c2_v_q;
		if (hw_q) begin
			c1_v_d = c1_nv_q;
			c2_v_d = c2_nv_q;
		end else if (commit) begin
			case (wsel)
				SEL_C1NV: begin
					c1_nv_d = lk.wr_data & CFG1_WMASK;
					c1_v_d = lk.wr_data & CFG1_WMASK;
				end
				SEL_C1V: begin
					c1_v_d = lk.wr_data & CFG1_WMASK;
				end
				SEL_C2NV: begin
					c2_nv_d = lk.wr_data & CFG2_WMASK;
					c2_v_d = lk.wr_data & CFG2_WMASK;
				end
				SEL_C2V: begin
					c2_v_d = lk.wr_data & CFG2_WMASK;
				end
				default: begin
					c1_v_d = c1_v_q;
				end
			endcase
		end
	end

	// power-up clears both copies to the factory default
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			c1_nv_q <= CFG_RESET;
			c1_v_q <= CFG_RESET;
			c2_nv_q <= CFG_RESET;
			c2_v_q <= CFG_RESET;
		end else begin
			c1_nv_q <= c1_nv_d;
			c1_v_q <= c1_v_d;
			c2_nv_q <= c2_nv_d;
			c2_v_q <= c2_v_d;
		end
	end

	// read path always sees the volatile copies
	assign lk.cfg1_vol = c1_v_q;
	assign lk.cfg2_vol = c2_v_q;

	// settings only move while no frame is under way
	always_comb begin
		eff1_d = sync_q[S_CS] ? c1_v_q : eff1_q;
		eff2_d = sync_q[S_CS] ? c2_v_q : eff2_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			eff1_q <= CFG_RESET;
			eff2_q <= CFG_RESET;
		end else begin
			eff1_q <= eff1_d;
			eff2_q <= eff2_d;
		end
	end

	assign four_lane_protocol_enable = eff2_q[CFG2_FOUR_BIT];
	assign two_lane_protocol_enable = eff2_q[CFG2_TWO_BIT];
	assign lane3_reset_alt_enable = eff2_q[CFG2_LANE3_RESET_ALT_ENABLE_BIT];
	assign quadd = eff1_q[CFG1_QUAD_BIT];
	assign cs_lo = ~sync_q[S_CS];

	// protocol and lane functions from the effective settings
	always_comb begin
		if (four_lane_protocol_enable && two_lane_protocol_enable)
			proto_d = SICF_SINGLE;
		else if (four_lane_protocol_enable)
			proto_d = SICF_QUAD;
		else if (two_lane_protocol_enable)
			proto_d = SICF_DUAL;
		else
			proto_d = SICF_SINGLE;
		// dual protocol ignores the quad data bit for the data width
		four_d = (quadd && proto_d == SICF_SINGLE) ||
			proto_d == SICF_QUAD;
		l3_data_d = cs_lo & four_d;
		// reset function outside frames, or in frames with quad data bit clear outside quad protocol
		l3_rst_d = lane3_reset_alt_enable & (~cs_lo |
			(~quadd & (proto_d != SICF_QUAD)));
		wp_d = four_d ? 1'b1 : sync_q[S_WP];
		hw_d = l3_rst_q & ~sync_q[S_L3];
		lat_d = eff1_q[LAT_MSB:LAT_LSB];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			proto_q <= SICF_SINGLE;
			four_q <= 1'b0;
			l3_data_q <= 1'b0;
			l3_rst_q <= 1'b0;
			wp_q <= 1'b1;
			hw_q <= 1'b0;
			lat_q <= 4'h0;
		end else begin
			proto_q <= proto_d;
			four_q <= four_d;
			l3_data_q <= l3_data_d;
			l3_rst_q <= l3_rst_d;
			wp_q <= wp_d;
			hw_q <= hw_d;
			lat_q <= lat_d;
		end
	end

	assign protocol_mode = proto_q;
	assign four_lane_data = four_q;
	assign lane2_is_data = four_q;
	assign lane3_is_data = l3_data_q;
	assign lane3_is_reset = l3_rst_q;
	assign write_protect_int = wp_q;
	assign hw_reset_active = hw_q;
	assign read_latency_code = lat_q;

	// checks on the system-clock side
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	a_default_zero: assert property ($past(!rst_n) |->
		c2_v_q == CFG_RESET && c2_nv_q == CFG_RESET)
		else $error("second config not zero after reset");

	a_reserved_clear: assert property (
		((c2_v_q | c2_nv_q) & ~CFG2_WMASK) == 8'h00)
		else $error("reserved bit set in second config");

	a_nv_write_both: assert property (
		commit && !hw_q && wsel == SEL_C2NV |=>
		c2_v_q == c2_nv_q && c2_v_q == ($past(lk.wr_data) & CFG2_WMASK))
		else $error("non-volatile write missed a copy");

	a_vol_write_only: assert property (
		commit && !hw_q && wsel == SEL_C2V |=> $stable(c2_nv_q))
		else $error("volatile write touched non-volatile copy");

	a_hw_reload: assert property (hw_q |=>
		c2_v_q == $past(c2_nv_q) && c1_v_q == $past(c1_nv_q))
		else $error("hardware reset did not reload volatile copy");

	a_eff_frame_hold: assert property (
		!sync_q[S_CS] |=> $stable(eff2_q) && $stable(eff1_q))
		else $error("settings changed during a frame");

	a_quad_select: assert property (
		four_lane_protocol_enable && !two_lane_protocol_enable |=> protocol_mode == SICF_QUAD)
		else $error("quad protocol not selected");

	a_dual_select: assert property (
		two_lane_protocol_enable && !four_lane_protocol_enable |=> protocol_mode == SICF_DUAL)
		else $error("dual protocol not selected");

	a_both_single: assert property (
		four_lane_protocol_enable && two_lane_protocol_enable |=> protocol_mode == SICF_SINGLE)
		else $error("both protocol bits must give single");

	a_lane_widen: assert property (
		quadd && !two_lane_protocol_enable |=> four_lane_data && lane2_is_data)
		else $error("quad data bit did not widen path");

	a_wp_forced: assert property (four_lane_data |->
		write_protect_int)
		else $error("write protect not forced high");

	a_lane3_split: assert property (
		quadd && lane3_reset_alt_enable && !two_lane_protocol_enable && !four_lane_protocol_enable ##1 quadd && lane3_reset_alt_enable |->
		(lane3_is_data != lane3_is_reset) && (lane3_is_reset == $past(~cs_lo)))
		else $error("lane 3 function wrong for chip select");

	a_latency_out: assert property (
		##1 read_latency_code == $past(eff1_q[LAT_MSB:LAT_LSB]))
		else $error("latency code not passed out");

	// pin level must pass through untouched outside four-lane width
	a_wp_passthru: assert property (
		!four_lane_data |-> write_protect_int == $past(sync_q[S_WP]))
		else $error("write protect pin not passed through");

	a_lane3_plain: assert property (
		!lane3_reset_alt_enable |=> !lane3_is_reset)
		else $error("lane 3 reset active without alternate function");

	a_pin_reset: assert property (
		lane3_is_reset && !sync_q[S_L3] |=> hw_reset_active)
		else $error("lane 3 reset pin not honoured");

	// dual protocol has no lane 2 or 3, whatever the quad data bit says
	a_dual_narrow: assert property (
		two_lane_protocol_enable && !four_lane_protocol_enable |=> !four_lane_data)
		else $error("dual protocol widened the data path");

	c_nv_write: cover property (commit && wsel == SEL_C2NV);
	c_hw_reset: cover property ($rose(hw_q));
	c_quad_proto: cover property (protocol_mode == SICF_QUAD);
	c_lane3_reset: cover property (lane3_is_reset && !sync_q[S_CS]);
	c_lane3_data: cover property (lane3_is_data);
endmodule

// File: test/sicf_host_model.sv
/*
 * Host controller model: drives single-lane register frames, mode 0.
 * Assumes the bench calls frame() one at a time; sck rests low between.
 */
`timescale 1ns/100ps
module sicf_host_model (
	output logic sck,
	output logic cs_n,
	output logic io0,
	input wire logic io1_out,
	input wire logic io1_oe
);
	logic [7:0] rd_q;
	logic last_q;

	// idle levels; no memory reads issued, so no latency picks
	initial begin
		sck = 1'b0;
		cs_n = 1'b0;
		io0 = 1'b0;
		rd_q = 8'h00;
		last_q = 1'b0;
		// a real rising select after time zero clears the link counter,
		// so the first frame never starts from an unknown count
		#1 cs_n = 1'b1;
	end

	// one frame: nin bits out msb first, then nout bits sampled in
	task automatic frame(input logic [39:0] v, input int nin,
		input int nout);
		int i;
		#3.3 cs_n = 1'b0;
		for (i = 0; i < nin; i++) begin
			io0 = v[39-i];
			#32 sck = 1'b1;
			#32 sck = 1'b0;
		end
		io0 = ~io0; // don't-care bits held at the inverse of the last driven bit
		for (i = 0; i < nout; i++) begin
			#32 sck = 1'b1;
			// released line shows the inverse, not a stale bit
			last_q = io1_oe ? io1_out : ~last_q;
			rd_q = {rd_q[6:0], last_q};
			#32 sck = 1'b0;
		end
		#32 cs_n = 1'b1;
		#400;
	endtask
endmodule

// File: test/sicf_cfg_top_tb_top.sv
/*
 * Self-checking bench for the configuration bank.
 * Assumes the host model in sicf_host_model.sv and sicf_pkg constants.
 */
`timescale 1ns/100ps
module sicf_cfg_top_tb_top;
	import sicf_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp_n_in = 1'b0;
	logic lane3_in = 1'b1;
	logic sck, cs_n, io0_in, io1_out, io1_oe;
	logic four_lane_data, lane2_is_data, lane3_is_data, lane3_is_reset;
	logic write_protect_int, hw_reset_active;
	logic [3:0] read_latency_code;
	sicf_proto_t protocol_mode;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	logic [7:0] vals [3] = '{8'h40, 8'h10, 8'h00};
	sicf_proto_t modes [3] = '{SICF_QUAD, SICF_DUAL, SICF_SINGLE};

	sicf_cfg_top i_sicf_cfg_top (.sys_clk(sys_clk), .rst_n(rst_n),
		.sck(sck), .cs_n(cs_n), .io0_in(io0_in), .wp_n_in(wp_n_in),
		.lane3_in(lane3_in), .io1_out(io1_out), .io1_oe(io1_oe),
		.protocol_mode(protocol_mode), .four_lane_data(four_lane_data),
		.lane2_is_data(lane2_is_data), .lane3_is_data(lane3_is_data),
		.lane3_is_reset(lane3_is_reset),
		.write_protect_int(write_protect_int),
		.hw_reset_active(hw_reset_active),
		.read_latency_code(read_latency_code));
	sicf_host_model i_sicf_host_model (.sck(sck), .cs_n(cs_n),
		.io0(io0_in), .io1_out(io1_out), .io1_oe(io1_oe));

	// system clock, 50 MHz
	always #10 sys_clk = ~sys_clk;

	// hang guard, well above the ~2550 cycles the tests need
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t pin got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		i_sicf_host_model.frame({WRITE_ANY_REGISTER_CMD, a, d}, 40, 0);
	endtask

	task automatic rd_any(input logic [23:0] a, input logic [7:0] exp);
		i_sicf_host_model.frame({READ_ANY_REGISTER_CMD, a, 8'h00}, 32, 8);
		chk_reg(i_sicf_host_model.rd_q, exp);
	endtask

	task automatic rd_two(input logic [7:0] exp);
		i_sicf_host_model.frame({READ_CFG_TWO_CMD, 32'h0}, 8, 8);
		chk_reg(i_sicf_host_model.rd_q, exp);
	endtask

	task automatic pins(input logic wp, input logic l3);
		@(posedge sys_clk);
		wp_n_in <= wp;
		lane3_in <= l3;
		repeat (8) @(posedge sys_clk);
	endtask

	// main sequence
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd_two(8'h00);
		rd_any(CFG2_NV_ADDR, 8'h00);
		chk_pin({2'h0, protocol_mode}, {2'h0, SICF_SINGLE});
		chk_pin({3'h0, write_protect_int}, 4'h0);
		$display("test reset done");
		wr(CFG2_VOL_ADDR, 8'hFF);
		rd_any(CFG2_VOL_ADDR, 8'h70);
		rd_any(24'h070009, 8'h00);
		chk_pin({2'h0, protocol_mode}, {2'h0, SICF_SINGLE});
		for (int k = 0; k < 3; k++) begin
			wr(CFG2_VOL_ADDR, vals[k]);
			chk_pin({2'h0, protocol_mode}, {2'h0, modes[k]});
			rd_two(vals[k]);
		end
		$display("test protocol done");
		wr(CFG2_NV_ADDR, 8'h20);
		rd_any(CFG2_VOL_ADDR, 8'h20);
		chk_pin({3'h0, lane3_is_reset}, 4'h1);
		wr(CFG2_VOL_ADDR, 8'h00);
		chk_pin({3'h0, lane3_is_reset}, 4'h0);
		rd_any(CFG2_NV_ADDR, 8'h00);
		wr(CFG2_VOL_ADDR, 8'h30);
		pins(1'b0, 1'b0);
		chk_pin({3'h0, hw_reset_active}, 4'h1);
		pins(1'b0, 1'b1);
		chk_pin({3'h0, hw_reset_active}, 4'h0);
		rd_two(8'h20);
		$display("test reload done");
		wr(CFG1_VOL_ADDR, 8'h72);
		chk_pin(read_latency_code, 4'h7);
		chk_pin({3'h0, four_lane_data}, 4'h1);
		chk_pin({3'h0, lane2_is_data}, 4'h1);
		chk_pin({3'h0, write_protect_int}, 4'h1);
		fork
			rd_two(8'h20);
			begin
				repeat (30) @(posedge sys_clk);
				chk_pin({3'h0, lane3_is_data}, 4'h1);
			end
		join
		chk_pin({3'h0, lane3_is_data}, 4'h0);
		chk_pin({3'h0, lane3_is_reset}, 4'h1);
		// short frame must leave the latency alone
		i_sicf_host_model.frame({WRITE_ANY_REGISTER_CMD, CFG1_VOL_ADDR,
			8'h00}, 36, 0);
		chk_pin(read_latency_code, 4'h7);
		$display("test quad done");
		report_and_stop();
	end
endmodule
